// >>> cta_pkg.sv
`default_nettype none
package cta_pkg;
  localparam int unsigned CNT_W = 16;
  localparam int unsigned CLK_PERIOD_NS = 100;
  localparam int unsigned START_LOW_NS = 3700000;
  localparam int unsigned START_NS = 4500000;
  localparam int unsigned START_DET_NS = 3500000;
  localparam int unsigned BIT_NS = 2400000;
  localparam int unsigned ZERO_LOW_NS = 1500000;
  localparam int unsigned ONE_LOW_NS = 600000;
  localparam int unsigned SAMPLE_NS = 1050000;
  localparam logic [CNT_W-1:0] START_LOW_CYC = CNT_W'(START_LOW_NS / CLK_PERIOD_NS);
  localparam logic [CNT_W-1:0] START_CYC = CNT_W'(START_NS / CLK_PERIOD_NS);
  localparam logic [CNT_W-1:0] START_DET_CYC = CNT_W'(START_DET_NS / CLK_PERIOD_NS);
  localparam logic [CNT_W-1:0] BIT_CYC = CNT_W'(BIT_NS / CLK_PERIOD_NS);
  localparam logic [CNT_W-1:0] ZERO_LOW_CYC = CNT_W'(ZERO_LOW_NS / CLK_PERIOD_NS);
  localparam logic [CNT_W-1:0] ONE_LOW_CYC = CNT_W'(ONE_LOW_NS / CLK_PERIOD_NS);
  localparam logic [CNT_W-1:0] SAMPLE_CYC = CNT_W'(SAMPLE_NS / CLK_PERIOD_NS);
  localparam logic [2:0] TICKS_BUS_ERR = 3'h2;
  localparam logic [2:0] TICKS_ARB = 3'h3;
  localparam logic [2:0] TICKS_START = 3'h4;
  localparam logic [2:0] FREE_BITS = 3'h7;
  localparam logic [3:0] SETTLE_CYC = 4'h4;
  localparam logic [3:0] LAST_BIT = 4'h9;
  localparam logic [3:0] EOM_BIT = 4'h8;
  localparam logic [3:0] DEST_BIT = 4'h7;
  localparam int unsigned SYNC_W = 2;
  localparam logic [2:0] ADDR_CTRL = 3'h0;
  localparam logic [2:0] ADDR_FREE = 3'h1;
  localparam logic [2:0] ADDR_TRANSMIT_FRAME_DATA = 3'h2;
  localparam logic [2:0] ADDR_RCV_ONE = 3'h3;
  localparam logic [2:0] ADDR_RCV_TWO = 3'h4;
  localparam logic [2:0] ADDR_STATUS = 3'h5;
  localparam int unsigned CTRL_TX_EN_POS = 0;
  localparam int unsigned ST_BUSY_POS = 0;
  localparam int unsigned ST_DONE_POS = 1;
  localparam int unsigned ST_ACKED_POS = 2;
  localparam int unsigned ST_BUSERR_POS = 3;
  localparam int unsigned ST_ARB_POS = 4;
  localparam int unsigned ST_EARLY_POS = 5;
  localparam int unsigned ST_LINE_POS = 6;
  localparam logic [3:0] FREE_SET_RST = 4'h0;
  localparam logic [3:0] RCV_ADDR_RST = 4'hF;
  localparam logic [3:0] NO_ADDR = 4'hF;
  typedef enum logic [3:0] {
    TX_IDLE = 4'h1,
    TX_WAIT = 4'h2,
    TX_START = 4'h4,
    TX_BITS = 4'h8
  } cta_tx_state_e;
endpackage : cta_pkg
`default_nettype wire

// >>> cta_pin_sync.sv
`default_nettype none
module cta_pin_sync (
  input wire logic clk,
  input wire logic reset,
  input wire logic ce,
  input wire logic [cta_pkg::SYNC_W-1:0] pin,
  output logic [cta_pkg::SYNC_W-1:0] level
);
  logic [cta_pkg::SYNC_W-1:0] s1;
  logic [cta_pkg::SYNC_W-1:0] s2;
  logic [cta_pkg::SYNC_W-1:0] s3;
  genvar i;
  for (i = 0; i < cta_pkg::SYNC_W; i++) begin : g_bit
    // level only moves when the last two stages agree
    always_ff @(posedge clk or posedge reset) begin
      if (reset) begin
        s1[i] <= 1'b1;
        s2[i] <= 1'b1;
        s3[i] <= 1'b1;
        level[i] <= 1'b1;
      end else if (ce) begin
        s1[i] <= pin[i];
        s2[i] <= s1[i];
        s3[i] <= s2[i];
        if (s2[i] == s3[i]) begin
          level[i] <= s3[i];
        end
      end
    end
  end
endmodule : cta_pin_sync
`default_nettype wire

// >>> cta_transmit_arb.sv
// Strobed register access and the address map were chosen for this implementation.
`default_nettype none
module cta_transmit_arb #(
  parameter logic [15:0] START_LOW_CYC = cta_pkg::START_LOW_CYC,
  parameter logic [15:0] START_CYC = cta_pkg::START_CYC,
  parameter logic [15:0] START_DET_CYC = cta_pkg::START_DET_CYC,
  parameter logic [15:0] BIT_CYC = cta_pkg::BIT_CYC,
  parameter logic [15:0] ZERO_LOW_CYC = cta_pkg::ZERO_LOW_CYC,
  parameter logic [15:0] ONE_LOW_CYC = cta_pkg::ONE_LOW_CYC,
  parameter logic [15:0] SAMPLE_CYC = cta_pkg::SAMPLE_CYC
) (
  input wire logic clk,
  input wire logic reset,
  input wire logic ce,
  input wire logic cec_line_in,
  output logic cec_line_out,
  output logic cec_line_oe,
  input wire logic slow_clk_in,
  input wire logic [2:0] reg_addr,
  input wire logic [7:0] reg_wdata,
  input wire logic reg_wr,
  input wire logic reg_rd,
  output logic [7:0] reg_rdata
);
  logic [cta_pkg::SYNC_W-1:0] sync_lv;
  logic line;
  logic line_q;
  logic slow_q;
  logic tx_en;
  logic [3:0] free_set;
  logic [7:0] tx_data;
  logic [3:0] rcv_one;
  logic [3:0] rcv_two;
  logic f_done, f_acked, f_buserr, f_arb, f_early;
  cta_pkg::cta_tx_state_e state, next_state;
  logic [15:0] tx_cnt, next_tx_cnt;
  logic [3:0] bit_idx, next_bit_idx;
  logic [9:0] shift;
  logic [2:0] tick_cnt;
  logic [3:0] settle;
  logic [15:0] idle_cnt;
  logic [2:0] idle_bits;
  logic in_frame, first_byte, addressed, eom, ack_drive;
  logic [15:0] rx_cnt;
  logic [3:0] rx_idx;
  logic [2:0] rx_sh;

  cta_pin_sync u_sync (
    .clk(clk),
    .reset(reset),
    .ce(ce),
    .pin({slow_clk_in, cec_line_in}),
    .level(sync_lv)
  );

  assign line = sync_lv[0];
  wire logic tick = sync_lv[1] & ~slow_q;
  wire logic line_fall = line_q & ~line;

  wire logic wr_ctrl = reg_wr && reg_addr == cta_pkg::ADDR_CTRL;
  wire logic wr_free = reg_wr && reg_addr == cta_pkg::ADDR_FREE;
  wire logic wr_data = reg_wr && reg_addr == cta_pkg::ADDR_TRANSMIT_FRAME_DATA;
  wire logic wr_one = reg_wr && reg_addr == cta_pkg::ADDR_RCV_ONE;
  wire logic wr_two = reg_wr && reg_addr == cta_pkg::ADDR_RCV_TWO;
  wire logic wr_stat = reg_wr && reg_addr == cta_pkg::ADDR_STATUS;

  wire logic st_idle = state == cta_pkg::TX_IDLE;
  wire logic st_wait = state == cta_pkg::TX_WAIT;
  wire logic st_start = state == cta_pkg::TX_START;
  wire logic st_bits = state == cta_pkg::TX_BITS;
  wire logic own_tx = st_start | st_bits;
  wire logic ack_slot = st_bits && bit_idx == cta_pkg::LAST_BIT;

  // driven level against the synchronised line, once the pin has settled
  wire logic settle_ok = settle == cta_pkg::SETTLE_CYC;
  wire logic mismatch = settle_ok && (line != ~cec_line_oe);
  wire logic arb_tx = (st_start || (st_bits && !ack_slot)) && mismatch;
  wire logic ev_early = st_wait && line_fall && tick_cnt < cta_pkg::TICKS_BUS_ERR;
  wire logic ev_buserr = st_wait && line_fall && tick_cnt == cta_pkg::TICKS_BUS_ERR;
  wire logic ev_arb_wait = st_wait && line_fall && tick_cnt >= cta_pkg::TICKS_ARB;
  wire logic ev_lost = arb_tx | ev_arb_wait;
  wire logic free_ok = free_set == 4'h0 || idle_bits == cta_pkg::FREE_BITS;
  wire logic go = st_wait && !line_fall && line && tick_cnt == cta_pkg::TICKS_START && free_ok;
  wire logic ev_acked = ack_slot && tx_cnt == SAMPLE_CYC && !line;
  wire logic ev_done = ack_slot && tx_cnt == BIT_CYC - 16'h0001;
  wire logic [15:0] low_len = shift[9] ? ONE_LOW_CYC : ZERO_LOW_CYC;
  wire logic tx_low = (st_start && tx_cnt < START_LOW_CYC) || (st_bits && tx_cnt < low_len);

  wire logic rx_sample = in_frame && rx_cnt == SAMPLE_CYC;
  wire logic [3:0] dest = {rx_sh, line};
  wire logic dest_match = dest != cta_pkg::NO_ADDR && (dest == rcv_one || dest == rcv_two);
  // own polling frame is never self-acknowledged
  wire logic ack_go = line_fall && in_frame && rx_idx == cta_pkg::LAST_BIT && addressed
    && !own_tx;

  always_comb begin
    next_state = state;
    next_tx_cnt = tx_cnt + 16'h0001;
    next_bit_idx = bit_idx;
    case (state)
      cta_pkg::TX_IDLE: begin
        next_tx_cnt = 16'h0000;
        if (wr_data && tx_en) begin
          next_state = cta_pkg::TX_WAIT;
        end
      end
      cta_pkg::TX_WAIT: begin
        next_tx_cnt = 16'h0000;
        if (line_fall) begin
          next_state = cta_pkg::TX_IDLE;
        end else if (go) begin
          next_state = cta_pkg::TX_START;
        end
      end
      cta_pkg::TX_START: begin
        if (tx_cnt == START_CYC - 16'h0001) begin
          next_state = cta_pkg::TX_BITS;
          next_tx_cnt = 16'h0000;
          next_bit_idx = 4'h0;
        end
      end
      cta_pkg::TX_BITS: begin
        if (tx_cnt == BIT_CYC - 16'h0001) begin
          next_tx_cnt = 16'h0000;
          next_bit_idx = bit_idx + 4'h1;
          if (ack_slot) begin
            next_state = cta_pkg::TX_IDLE;
          end
        end
      end
      default: next_state = cta_pkg::TX_IDLE;
    endcase
    if (arb_tx || !tx_en) begin
      next_state = cta_pkg::TX_IDLE;
    end
  end

  always_ff @(posedge clk or posedge reset) begin
    if (reset) begin
      state <= cta_pkg::TX_IDLE;
      tx_cnt <= 16'h0000;
      bit_idx <= 4'h0;
    end else if (ce) begin
      state <= next_state;
      tx_cnt <= next_tx_cnt;
      bit_idx <= next_bit_idx;
    end
  end

  always_ff @(posedge clk or posedge reset) begin
    if (reset) begin
      shift <= 10'h000;
      tick_cnt <= 3'h0;
    end else if (ce) begin
      if (st_idle) begin
        shift <= {wr_data ? reg_wdata : tx_data, 2'h3};
        tick_cnt <= 3'h0;
      end else if (st_wait && tick && tick_cnt != cta_pkg::TICKS_START) begin
        tick_cnt <= tick_cnt + 3'h1;
      end else if (st_bits && tx_cnt == BIT_CYC - 16'h0001) begin
        shift <= {shift[8:0], 1'b1};
      end
    end
  end

  // released line drives the signal-free count
  always_ff @(posedge clk or posedge reset) begin
    if (reset) begin
      idle_cnt <= 16'h0000;
      idle_bits <= 3'h0;
    end else if (ce) begin
      if (!line) begin
        idle_cnt <= 16'h0000;
        idle_bits <= 3'h0;
      end else if (idle_cnt == BIT_CYC - 16'h0001) begin
        idle_cnt <= 16'h0000;
        if (idle_bits != cta_pkg::FREE_BITS) begin
          idle_bits <= idle_bits + 3'h1;
        end
      end else begin
        idle_cnt <= idle_cnt + 16'h0001;
      end
    end
  end

  always_ff @(posedge clk or posedge reset) begin
    if (reset) begin
      line_q <= 1'b1;
      slow_q <= 1'b1;
      settle <= 4'h0;
      cec_line_oe <= 1'b0;
      cec_line_out <= 1'b0;
    end else if (ce) begin
      line_q <= line;
      slow_q <= sync_lv[1];
      cec_line_oe <= tx_low | ack_drive;
      if (cec_line_oe != (tx_low | ack_drive)) begin
        settle <= 4'h0;
      end else if (!settle_ok) begin
        settle <= settle + 4'h1;
      end
    end
  end

  always_ff @(posedge clk or posedge reset) begin
    if (reset) begin
      rx_cnt <= 16'h0000;
      in_frame <= 1'b0;
      rx_idx <= 4'h0;
      rx_sh <= 3'h0;
      first_byte <= 1'b0;
      addressed <= 1'b0;
      eom <= 1'b0;
    end else if (ce) begin
      if (line_fall) begin
        rx_cnt <= 16'h0000;
      end else if (rx_cnt != 16'hFFFF) begin
        rx_cnt <= rx_cnt + 16'h0001;
      end
      if (!in_frame && !line && rx_cnt == START_DET_CYC) begin
        in_frame <= 1'b1;
        rx_idx <= 4'h0;
        first_byte <= 1'b1;
        addressed <= 1'b0;
      end else if (in_frame && line && rx_cnt == START_CYC) begin
        in_frame <= 1'b0;
      end else if (rx_sample) begin
        rx_sh <= {rx_sh[1:0], line};
        if (rx_idx == cta_pkg::DEST_BIT && first_byte) begin
          addressed <= dest_match;
        end
        if (rx_idx == cta_pkg::EOM_BIT) begin
          eom <= line;
        end
        if (rx_idx == cta_pkg::LAST_BIT) begin
          rx_idx <= 4'h0;
          first_byte <= 1'b0;
          in_frame <= !eom;
        end else begin
          rx_idx <= rx_idx + 4'h1;
        end
      end
    end
  end

  always_ff @(posedge clk or posedge reset) begin
    if (reset) begin
      ack_drive <= 1'b0;
    end else if (ce) begin
      if (ack_go) begin
        ack_drive <= 1'b1;
      end else if (rx_cnt == ZERO_LOW_CYC) begin
        ack_drive <= 1'b0;
      end
    end
  end

  always_ff @(posedge clk or posedge reset) begin
    if (reset) begin
      tx_en <= 1'b0;
      free_set <= cta_pkg::FREE_SET_RST;
      tx_data <= 8'h00;
      rcv_one <= cta_pkg::RCV_ADDR_RST;
      rcv_two <= cta_pkg::RCV_ADDR_RST;
    end else if (ce) begin
      if (wr_ctrl) tx_en <= reg_wdata[cta_pkg::CTRL_TX_EN_POS];
      if (wr_free) free_set <= reg_wdata[3:0];
      if (wr_data) tx_data <= reg_wdata;
      if (wr_one) rcv_one <= reg_wdata[3:0];
      if (wr_two) rcv_two <= reg_wdata[3:0];
    end
  end

  // sticky flags, write one to clear, a new event beats the clear
  wire logic [4:0] clr = wr_stat ? reg_wdata[5:1] : 5'h00;
  always_ff @(posedge clk or posedge reset) begin
    if (reset) begin
      {f_early, f_arb, f_buserr, f_acked, f_done} <= 5'h00;
    end else if (ce) begin
      f_done <= ev_done | (f_done & ~clr[0]);
      f_acked <= ev_acked | (f_acked & ~clr[1]);
      f_buserr <= ev_buserr | (f_buserr & ~clr[2]);
      f_arb <= ev_lost | (f_arb & ~clr[3]);
      f_early <= ev_early | (f_early & ~clr[4]);
    end
  end

  wire logic [7:0] status = {1'b0, line, f_early, f_arb, f_buserr, f_acked, f_done, !st_idle};
  wire logic [7:0] rd_word =
    reg_addr == cta_pkg::ADDR_CTRL ? {7'h00, tx_en} :
    reg_addr == cta_pkg::ADDR_FREE ? {4'h0, free_set} :
    reg_addr == cta_pkg::ADDR_TRANSMIT_FRAME_DATA ? tx_data :
    reg_addr == cta_pkg::ADDR_RCV_ONE ? {4'h0, rcv_one} :
    reg_addr == cta_pkg::ADDR_RCV_TWO ? {4'h0, rcv_two} :
    reg_addr == cta_pkg::ADDR_STATUS ? status : 8'h00;

  always_ff @(posedge clk or posedge reset) begin
    if (reset) begin
      reg_rdata <= 8'h00;
    end else if (ce) begin
      reg_rdata <= reg_rd ? rd_word : 8'h00;
    end
  end

  default clocking cb @(posedge clk iff ce); endclocking
  default disable iff (reset);

  sequence s_armed;
    st_idle && wr_data && tx_en;
  endsequence
  sequence s_ack_due;
    line_fall && in_frame && rx_idx == cta_pkg::LAST_BIT && addressed && !own_tx;
  endsequence

  a_arb_abort: assert property (
    own_tx && settle_ok && line == cec_line_oe && !ack_slot |=> st_idle && f_arb)
    else $error("mismatch did not abandon frame");
  a_lost_release: assert property (
    ev_lost |=> ##1 (cec_line_oe == $past(ack_drive)))
    else $error("line still driven after lost arbitration");
  a_write_arms: assert property (
    s_armed |=> st_wait && tick_cnt == 3'h0)
    else $error("data write did not arm the start wait");
  a_start_tick: assert property (
    $rose(st_start) |-> $past(tick_cnt) == cta_pkg::TICKS_START && $past(st_wait))
    else $error("frame started outside tick window");
  a_bus_err: assert property (
    st_wait && line_fall && tick_cnt == cta_pkg::TICKS_BUS_ERR |=> f_buserr && st_idle)
    else $error("bus error not reported");
  a_wait_lost: assert property (
    st_wait && line_fall && tick_cnt == cta_pkg::TICKS_ARB |=> f_arb && st_idle)
    else $error("lost arbitration not reported in wait");
  a_poll_ack: assert property (
    s_ack_due |=> ##1 cec_line_oe)
    else $error("addressed frame not acknowledged");
  a_free_wait: assert property (
    $rose(st_start) |-> $past(free_set == 4'h0 || idle_bits == cta_pkg::FREE_BITS))
    else $error("initiated without signal free time");
endmodule : cta_transmit_arb
`default_nettype wire

// >>> cta_node_model.sv
`default_nettype none
module cta_node_model #(
  parameter logic [15:0] BIT = 16'h00F0,
  parameter logic [15:0] START = 16'h01C2,
  parameter logic [15:0] START_LOW = 16'h0172,
  parameter logic [15:0] START_DET = 16'h015E,
  parameter logic [15:0] ZERO_LOW = 16'h0096,
  parameter logic [15:0] ONE_LOW = 16'h003C,
  parameter logic [15:0] SAMPLE = 16'h0069
) (
  input wire logic clk,
  input wire logic line,
  output logic pull
);
  timeunit 1ns;
  timeprecision 1ns;
  logic ack_en = 1'b1;
  logic sending = 1'b0;
  int arb_bit = 99;
  logic [7:0] rx_q [$];
  initial pull = 1'b0;
  // one whole frame of our own, ack slot sampled
  task automatic send_frame(input logic [7:0] hdr, output logic acked);
    logic b;
    sending = 1'b1;
    acked = 1'b0;
    for (int n = -1; n < 10; n++) begin
      b = (n < 0) ? 1'b0 : (n < 8) ? hdr[7-n] : 1'b1;
      for (int c = 0; c < ((n < 0) ? START : BIT); c++) begin
        @(posedge clk);
        pull <= (n < 0) ? (c < START_LOW) : (c < (b ? ONE_LOW : ZERO_LOW));
        if (n == 9 && c == SAMPLE) acked = !line;
      end
    end
    @(posedge clk);
    pull <= 1'b0;
    sending = 1'b0;
  endtask : send_frame
  // follow frames of others; ack, or overwrite a one bit to win
  always begin : follow
    logic [7:0] d;
    int t;
    @(negedge line);
    if (!sending) begin
      repeat (START_DET) @(posedge clk);
      t = 0;
      for (int n = 0; n < 10 && t < 4 * BIT; n++) begin
        t = 0;
        while (!line && t < 4 * BIT) begin
          @(posedge clk);
          t++;
        end
        while (line && t < 4 * BIT) begin
          @(posedge clk);
          t++;
        end
        if (t < 4 * BIT) begin
          pull <= (n == 9 && ack_en) || n == arb_bit;
          repeat (SAMPLE) @(posedge clk);
          if (n < 8) d[7-n] = line;
          repeat (ZERO_LOW - SAMPLE) @(posedge clk);
          pull <= 1'b0;
          if (n == 9) rx_q.push_back(d);
        end
      end
    end
  end
endmodule : cta_node_model
`default_nettype wire

// >>> cta_transmit_arb_tb.sv
`default_nettype none
module cta_transmit_arb_tb;
  timeunit 1ns;
  timeprecision 1ns;
  localparam logic [15:0] P_BIT = 16'h00F0;
  localparam logic [15:0] P_START = 16'h01C2;
  localparam logic [15:0] P_START_LOW = 16'h0172;
  localparam logic [15:0] P_START_DET = 16'h015E;
  localparam logic [15:0] P_ZERO_LOW = 16'h0096;
  localparam logic [15:0] P_ONE_LOW = 16'h003C;
  localparam logic [15:0] P_SAMPLE = 16'h0069;
  logic clk = 1'b0;
  logic reset = 1'b1;
  logic slow_clk = 1'b0;
  logic [2:0] reg_addr = 3'h0;
  logic [7:0] reg_wdata = 8'h00;
  logic reg_wr = 1'b0;
  logic reg_rd = 1'b0;
  logic [7:0] reg_rdata;
  logic cec_line_out;
  logic cec_line_oe;
  logic node_pull;
  logic acked;
  logic [7:0] data;
  int seed = 32'h15c2e6a7;
  int bad_count = 0;
  int checks = 0;
  int cyc = 0;
  int t_rise = 0;
  // open-drain wire with pull-up
  wire line = ~((cec_line_oe & ~cec_line_out) | node_pull);
  always #50 clk = ~clk;
  always #15259 slow_clk = ~slow_clk;
  always @(posedge clk) cyc <= cyc + 1;
  always @(posedge line) t_rise = cyc;
  cta_transmit_arb #(
    .START_LOW_CYC(P_START_LOW), .START_CYC(P_START), .START_DET_CYC(P_START_DET),
    .BIT_CYC(P_BIT), .ZERO_LOW_CYC(P_ZERO_LOW), .ONE_LOW_CYC(P_ONE_LOW), .SAMPLE_CYC(P_SAMPLE)
  ) cta_transmit_arb_i (
    .clk(clk), .reset(reset), .ce(1'b1), .cec_line_in(line), .cec_line_out(cec_line_out),
    .cec_line_oe(cec_line_oe), .slow_clk_in(slow_clk), .reg_addr(reg_addr),
    .reg_wdata(reg_wdata), .reg_wr(reg_wr), .reg_rd(reg_rd), .reg_rdata(reg_rdata)
  );
  cta_node_model #(
    .BIT(P_BIT), .START(P_START), .START_LOW(P_START_LOW), .START_DET(P_START_DET),
    .ZERO_LOW(P_ZERO_LOW), .ONE_LOW(P_ONE_LOW), .SAMPLE(P_SAMPLE)
  ) cta_node_model_i (.clk(clk), .line(line), .pull(node_pull));
  task automatic check(input logic [7:0] got, input logic [7:0] exp);
    checks++;
    if (got !== exp) begin
      bad_count++;
      $display("ERROR t=%0t got=%h exp=%h", $time, got, exp);
    end
  endtask : check
  task automatic wr(input logic [2:0] a, input logic [7:0] d);
    @(posedge clk);
    reg_addr <= a;
    reg_wdata <= d;
    reg_wr <= 1'b1;
    @(posedge clk);
    reg_wr <= 1'b0;
  endtask : wr
  task automatic rd(input logic [2:0] a, input logic [7:0] exp);
    @(posedge clk);
    reg_addr <= a;
    reg_rd <= 1'b1;
    @(posedge clk);
    reg_rd <= 1'b0;
    @(negedge clk);
    check(reg_rdata, exp);
  endtask : rd
  // write well clear of a slow tick
  task automatic send(input logic [7:0] d);
    @(posedge slow_clk);
    repeat (20) @(posedge clk);
    wr(cta_pkg::ADDR_TRANSMIT_FRAME_DATA, d);
  endtask : send
  task automatic wait_oe(output int dt);
    int t;
    t = cyc;
    while (cec_line_oe !== 1'b1 && cyc - t < 4000) @(negedge clk);
    dt = cyc - t;
  endtask : wait_oe
  task automatic frame_done;
    logic [7:0] q;
    q = 8'hXX;
    repeat (P_START + 10 * P_BIT + 20) @(posedge clk);
    if (cta_node_model_i.rx_q.size() > 0) q = cta_node_model_i.rx_q.pop_front();
    check(q, data);
    rd(cta_pkg::ADDR_STATUS, 8'h46);
    wr(cta_pkg::ADDR_STATUS, 8'h3E);
  endtask : frame_done
  task automatic finish_test;
    $display("checks=%0d bad_count=%0d", checks, bad_count);
    if (bad_count == 0 && checks > 0) begin
      $display("All checks passed");
    end else begin
      $display("Checks failed");
    end
    $finish;
  endtask : finish_test
  initial begin
    logic [7:0] rst_v [8];
    logic [7:0] fl [3];
    int tk [3];
    int dt;
    rst_v = '{8'h00, 8'h00, 8'h00, 8'h0F, 8'h0F, 8'h40, 8'h00, 8'h00};
    fl = '{8'h60, 8'h48, 8'h50};
    tk = '{0, 2, 3};
    repeat (16) @(posedge clk);
    reset <= 1'b0;
    for (int i = 0; i < 8; i++) rd(3'(i), rst_v[i]);
    data = 8'($random(seed));
    wr(cta_pkg::ADDR_RCV_TWO, data);
    rd(cta_pkg::ADDR_RCV_TWO, {4'h0, data[3:0]});
    wr(3'h6, data);
    rd(3'h6, 8'h00);
    wr(cta_pkg::ADDR_RCV_ONE, 8'h04);
    wr(cta_pkg::ADDR_CTRL, 8'h01);
    for (int k = 0; k < 3; k++) begin
      data = (k == 0) ? 8'hFF : 8'($random(seed));
      send(data);
      wait_oe(dt);
      check(8'(dt >= 915 && dt <= 1230), 8'h01);
      frame_done();
    end
    data = {2'b01, 6'($random(seed))};
    cta_node_model_i.arb_bit = 1;
    send(data);
    wait_oe(dt);
    repeat (P_START + 2 * P_BIT + 20) @(posedge clk);
    cta_node_model_i.arb_bit = 99;
    check({7'h00, cec_line_oe}, 8'h00);
    rd(cta_pkg::ADDR_STATUS, 8'h50);
    wr(cta_pkg::ADDR_STATUS, 8'h3E);
    repeat (5 * P_BIT) @(posedge clk);
    wr(cta_pkg::ADDR_RCV_ONE, 8'h0F);
    wr(cta_pkg::ADDR_RCV_TWO, 8'h0F);
    cta_node_model_i.send_frame(8'h44, acked);
    check({7'h00, acked}, 8'h00);
    wr(cta_pkg::ADDR_RCV_ONE, 8'h04);
    for (int k = 0; k < 3; k++) begin
      send(data);
      repeat (tk[k]) @(posedge slow_clk);
      repeat (50) @(posedge clk);
      cta_node_model_i.send_frame(8'h44, acked);
      check({7'h00, acked}, 8'h01);
      rd(cta_pkg::ADDR_STATUS, fl[k]);
      wr(cta_pkg::ADDR_STATUS, 8'h3E);
      wr(cta_pkg::ADDR_CTRL, 8'h00);
      wr(cta_pkg::ADDR_CTRL, 8'h01);
    end
    wr(cta_pkg::ADDR_FREE, 8'h01);
    cta_node_model_i.send_frame(8'h22, acked);
    wr(cta_pkg::ADDR_TRANSMIT_FRAME_DATA, data);
    wait_oe(dt);
    check(8'(cyc - t_rise >= 7 * P_BIT), 8'h01);
    frame_done();
    finish_test();
  end
  initial begin
    repeat (90000) @(posedge clk);
    bad_count++;
    finish_test();
  end
endmodule : cta_transmit_arb_tb
`default_nettype wire
